// ==== design/fife_coef_mem.sv ====
// coefficient store with registered read data
`timescale 1ns/1ps
`default_nettype none
module fife_coef_mem #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 32,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output var logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read port, data out of a register
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ==== design/fife_front_end.sv ====
// filter input front end: coefficient port, serial inputs, mixer
`timescale 1ns/1ps
`default_nettype none
//Behaviour
// [R1] store 128 coefficients of 32 bits, four byte writes each, LSB first
// [R2] bytes gather in staging; fourth write commits word and advances pointer
// [R3] host clears read enable, then writes bytes at select code 010
// [R4] write pointer halts at 128; later coefficient writes are dropped
// [R5] access to any other configuration register rewinds coefficient pointers
// [R6] coefficient loading is never blocked by filtering in progress
// [R7] symmetric filters load unique half only, up to 256 taps
// [R8] asymmetric filters load all taps, at most 128, length doubled
// [R9] setting read enable rewinds read pointer and blocks coefficient writes
// [R10] with read enable and code 010, each read fall gives next byte
// [R11] host never drops read strobe while write strobe is low
// [R12] sample bit taken each serial rise; marker one clock before bit one
// [R13] shifting holds at programmed length; next marker moves word to holding
// [R14] two's complement or offset binary, either order, left aligned
// [R15] sample marker high for at most one serial clock
// [R16] serial mix word framed by its marker, held, moved left aligned
// [R17] table source with both mix pins high multiplies by unity
// [R18] table decode: 00 zero, 01 minus one, 10 zero, 11 plus one
// [R19] table mode: sample marker loads table output, decodes new pins
// [R20] sender presents table selection one sample period early
// [R21] marker loads mix into multiplier, then input bits; result to compute
// [R22] serial mix factor loaded alongside its sample, marker may lead
// [R23] input format: length in five low bits, bit5 offset, bit6 MSB first
// [R24] mix format bit 6 picks serial input or table
// [R25] products and input words cross to compute clock by handshake
module fife_front_end (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic serial_clk,
  input wire logic [2:0] register_select_lines,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] config_byte_bus_in,
  output var logic [7:0] config_byte_bus_out,
  output var logic config_byte_bus_oe_n,
  input wire logic sample_serial_in,
  input wire logic sample_word_marker,
  input wire logic mix_serial_in,
  input wire logic mix_word_marker,
  output var logic [fife_pkg::WORD_W-1:0] product_word,
  output var logic [fife_pkg::WORD_W-1:0] sample_word,
  output var logic product_valid,
  output var logic [fife_pkg::WPTR_W-1:0] coef_write_ptr
);
  typedef enum logic {FIFE_MUL_IDLE, FIFE_MUL_RUN} fife_mul_state_t;

  // ---------------- compute clock domain ----------------
  logic [12:0] pin_s1, pin_s2, pin_s3;
  logic wr_n_stable, rd_n_stable;
  logic wr_done, rd_fall, rd_rise;
  logic [2:0] acc_addr;
  logic [7:0] acc_data;
  logic [7:0] cfg [fife_pkg::NUM_CFG_REGS];
  logic [23:0] stage;
  logic [1:0] byte_cnt;
  logic [fife_pkg::RPTR_W-1:0] rd_ptr;
  logic [fife_pkg::COEF_W-1:0] mem_rdata;
  logic mem_we;
  logic read_en;
  logic coef_access, other_access;

  // pins pass three flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1 <= 13'h1800;
      pin_s2 <= 13'h1800;
      pin_s3 <= 13'h1800;
    end else begin
      pin_s1 <= {write_strobe_n, read_strobe_n, register_select_lines,
                 config_byte_bus_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // a strobe change counts once second and third stage agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_n_stable <= 1'b1;
      rd_n_stable <= 1'b1;
    end else begin
      if (pin_s2[12] == pin_s3[12]) begin
        wr_n_stable <= pin_s3[12];
      end
      if (pin_s2[11] == pin_s3[11]) begin
        rd_n_stable <= pin_s3[11];
      end
    end
  end

  assign acc_addr = pin_s3[10:8];
  assign acc_data = pin_s3[7:0];
  assign wr_done = !wr_n_stable && (pin_s2[12] == pin_s3[12]) && pin_s3[12];
  // read only counts with write idle; host never overlaps them, see [R11]
  assign rd_fall = rd_n_stable && (pin_s2[11] == pin_s3[11]) && !pin_s3[11]
                   && wr_n_stable;
  assign rd_rise = !rd_n_stable && (pin_s2[11] == pin_s3[11]) && pin_s3[11];
  assign read_en = cfg[fife_pkg::ADDR_FILTER_CFG][fife_pkg::RD_EN_BIT];
  assign coef_access = (acc_addr == fife_pkg::ADDR_COEF_PORT);
  assign other_access = (wr_done || rd_fall) && !coef_access;

  // configuration bytes; the coefficient code holds none
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < fife_pkg::NUM_CFG_REGS; i++) begin
        cfg[i] <= fife_pkg::CFG_RESET;
      end
    end else if (wr_done && !coef_access) begin
      cfg[acc_addr] <= acc_data;
    end
  end

  // commit on fourth byte, not while reading or past the end
  assign mem_we = wr_done && coef_access && !read_en  // see [R9]
                  && (byte_cnt == fife_pkg::LAST_BYTE)  // see [R2]
                  && (coef_write_ptr < 8'(fife_pkg::COEF_ENTRIES));  // see [R4]

  // staging register and byte counter, LSB first, see [R1]
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage <= '0;
      byte_cnt <= '0;
    end else if (other_access) begin
      byte_cnt <= '0;  // see [R5]
    end else if (wr_done && coef_access && !read_en) begin
      // filter activity never gates this path, see [R6]
      stage <= {acc_data, stage[23:8]};
      byte_cnt <= byte_cnt + 2'h1;
    end
  end

  // write pointer: advance on commit, halt at the end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      coef_write_ptr <= '0;
    end else if (other_access) begin
      coef_write_ptr <= '0;  // see [R5]
    end else if (mem_we) begin
      coef_write_ptr <= coef_write_ptr + 8'h01;  // see [R2] [R4]
    end
  end

  // read pointer: rewound by read enable being set or other access
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_ptr <= '0;
    end else if (other_access) begin
      rd_ptr <= '0;  // see [R5] [R9]
    end else if (rd_fall && coef_access && read_en) begin
      rd_ptr <= rd_ptr + 9'h001;  // see [R10]
    end
  end

  fife_coef_mem #(
    .DEPTH(fife_pkg::COEF_ENTRIES),
    .WIDTH(fife_pkg::COEF_W),
    .AW(7)
  ) u_mem (
    .clk(ref_clk),
    .we(mem_we),
    .waddr(coef_write_ptr[6:0]),
    .wdata({acc_data, stage}),
    .raddr(rd_ptr[8:2]),
    .rdata(mem_rdata)
  );

  // read data and bus drive, enable low while driving
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      config_byte_bus_out <= '0;
      config_byte_bus_oe_n <= 1'b1;
    end else if (rd_fall) begin
      config_byte_bus_oe_n <= 1'b0;
      if (!coef_access) begin
        config_byte_bus_out <= cfg[acc_addr];
      end else if (read_en) begin
        // next byte in written order, see [R10]
        config_byte_bus_out <= mem_rdata[rd_ptr[1:0]*8 +: 8];
      end else begin
        config_byte_bus_out <= '0;
      end
    end else if (rd_rise) begin
      config_byte_bus_oe_n <= 1'b1;
    end
  end

  // ---------------- serial clock domain ----------------
  logic [15:0] fmt_s1, fmt_s2;
  logic [7:0] in_fmt, mix_fmt;
  logic [fife_pkg::WORD_W-1:0] sample_hold, mix_shift_hold, sample_val;
  logic [fife_pkg::MIX_W-1:0] lut_out, lut_hold, mix_val, next_lut;
  logic mix_serial_mode, start;
  fife_mul_state_t mul_state;
  logic [4:0] step;
  logic signed [fife_pkg::MIX_W-1:0] mcand;
  logic [fife_pkg::WORD_W-1:0] mplier;
  logic signed [fife_pkg::PROD_W-1:0] prod, partial, next_prod;
  logic [fife_pkg::WORD_W-1:0] xfer_prod, xfer_sample;
  logic xfer_tgl;

  // static format bytes taken over by two flops
  always_ff @(posedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      fmt_s1 <= '0;
      fmt_s2 <= '0;
    end else begin
      fmt_s1 <= {cfg[fife_pkg::ADDR_MIX_FORMAT],
                 cfg[fife_pkg::ADDR_IN_FORMAT]};
      fmt_s2 <= fmt_s1;
    end
  end

  assign in_fmt = fmt_s2[7:0];
  assign mix_fmt = fmt_s2[15:8];
  assign mix_serial_mode = mix_fmt[fife_pkg::MIX_SRC_SERIAL_BIT];  // see [R24]

  // sample path, see [R12] [R13] [R23]; marker width kept by sender, see [R15]
  fife_shift #(.WIDTH(fife_pkg::WORD_W)) u_sample (
    .clk(serial_clk),
    .rstn(rstn),
    .bit_in(sample_serial_in),
    .marker(sample_word_marker),
    .word_len(in_fmt[fife_pkg::LEN_W-1:0]),
    .msb_first(in_fmt[fife_pkg::IN_MSB_FIRST_BIT]),
    .hold_word(sample_hold)
  );

  // mix path in serial mode, see [R16] [R22]
  fife_shift #(.WIDTH(fife_pkg::WORD_W)) u_mix (
    .clk(serial_clk),
    .rstn(rstn),
    .bit_in(mix_serial_in),
    .marker(mix_word_marker),
    .word_len(mix_fmt[fife_pkg::LEN_W-1:0]),
    .msb_first(mix_fmt[fife_pkg::MIX_MSB_FIRST_BIT]),
    .hold_word(mix_shift_hold)
  );

  // offset binary turned to two's complement by the sign flip, see [R14]
  assign sample_val = sample_hold
    ^ {in_fmt[fife_pkg::IN_OFFSET_BIT], 23'h000000};

  // quarter-rate table decode of marker and data pins, see [R18] [R17]
  always_comb begin
    unique case ({mix_word_marker, mix_serial_in})
      2'b01: next_lut = fife_pkg::MIX_MINUS_ONE;
      2'b11: next_lut = fife_pkg::MIX_PLUS_ONE;
      default: next_lut = fife_pkg::MIX_ZERO;
    endcase
  end

  // table stage: sample marker loads holding, decodes anew, see [R19] [R20]
  always_ff @(posedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      lut_out <= fife_pkg::MIX_ZERO;
      lut_hold <= fife_pkg::MIX_ZERO;
    end else if (sample_word_marker) begin
      lut_hold <= lut_out;
      lut_out <= next_lut;
    end
  end

  assign mix_val = mix_serial_mode ? {mix_shift_hold[23], mix_shift_hold}
                                   : lut_hold;

  // start one clock after the marker so holding registers are settled
  always_ff @(posedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      start <= 1'b0;
    end else begin
      start <= sample_word_marker;  // see [R21]
    end
  end

  // shift-add step; top sample bit carries negative weight
  always_comb begin
    partial = '0;
    if (mplier[0]) begin
      // sign extend the mix factor to the product width
      partial = {{(fife_pkg::PROD_W - fife_pkg::MIX_W){
                  mcand[fife_pkg::MIX_W-1]}}, mcand};
      if (step == fife_pkg::LAST_STEP) begin
        partial = -partial;
      end
    end
    next_prod = prod + (partial <<< step);
  end

  // serial multiplier: load mix, then one input bit per clock, see [R21]
  always_ff @(posedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      mul_state <= FIFE_MUL_IDLE;
      step <= '0;
      mcand <= '0;
      mplier <= '0;
      prod <= '0;
    end else if (start) begin
      mul_state <= FIFE_MUL_RUN;
      step <= '0;
      mcand <= mix_val;
      mplier <= sample_val;
      prod <= '0;
    end else begin
      unique case (mul_state)
        FIFE_MUL_IDLE: begin
          step <= '0;
        end
        FIFE_MUL_RUN: begin
          prod <= next_prod;
          mplier <= {1'b0, mplier[23:1]};
          step <= step + 5'h01;
          if (step == fife_pkg::LAST_STEP) begin
            mul_state <= FIFE_MUL_IDLE;
          end
        end
      endcase
    end
  end

  // finished product and its sample held for the crossing, see [R25]
  always_ff @(posedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      xfer_prod <= '0;
      xfer_sample <= '0;
      xfer_tgl <= 1'b0;
    end else if (mul_state == FIFE_MUL_RUN && step == fife_pkg::LAST_STEP
                 && !start) begin
      xfer_prod <= next_prod[46:23];
      xfer_sample <= sample_val;
      xfer_tgl <= !xfer_tgl;
    end
  end

  // ---------------- back into the compute domain ----------------
  logic tgl_s1, tgl_s2, tgl_s3;

  // toggle passes two flops, third one finds the edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= xfer_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // held words are stable when the toggle edge arrives, see [R25] [R21]
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      product_word <= '0;
      sample_word <= '0;
      product_valid <= 1'b0;
    end else begin
      product_valid <= tgl_s2 ^ tgl_s3;
      if (tgl_s2 ^ tgl_s3) begin
        product_word <= xfer_prod;
        sample_word <= xfer_sample;
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/fife_pkg.sv ====
// package of constants shared by the filter input front end
package fife_pkg;
  // register select codes
  localparam logic [2:0] ADDR_FILTER_CFG = 3'h0;
  localparam logic [2:0] ADDR_COEF_PORT = 3'h2;
  localparam logic [2:0] ADDR_IN_FORMAT = 3'h3;
  localparam logic [2:0] ADDR_MIX_FORMAT = 3'h7;
  localparam int NUM_CFG_REGS = 8;
  // field positions
  localparam int RD_EN_BIT = 4;
  localparam int LEN_W = 5;
  localparam int IN_OFFSET_BIT = 5;
  localparam int IN_MSB_FIRST_BIT = 6;
  localparam int MIX_MSB_FIRST_BIT = 5;
  localparam int MIX_SRC_SERIAL_BIT = 6;
  // reset value of every configuration byte
  localparam logic [7:0] CFG_RESET = 8'h00;
  // coefficient store geometry
  localparam int COEF_ENTRIES = 128;
  localparam int COEF_W = 32;
  localparam int BYTES_PER_COEF = 4;
  localparam int WPTR_W = 8;
  localparam int RPTR_W = 9;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  // serial word geometry
  localparam int WORD_W = 24;
  localparam int MIX_W = 25;
  localparam int PROD_W = 49;
  localparam logic [4:0] LAST_STEP = 5'h17;
  // quarter-rate table values, unity is two to the 23rd
  localparam logic [MIX_W-1:0] MIX_ZERO = 25'h0000000;
  localparam logic [MIX_W-1:0] MIX_PLUS_ONE = 25'h0800000;
  localparam logic [MIX_W-1:0] MIX_MINUS_ONE = 25'h1800000;
endpackage

// ==== design/fife_shift.sv ====
// variable length serial shift register with holding register
`timescale 1ns/1ps
`default_nettype none
module fife_shift #(
  parameter int WIDTH = 24
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic bit_in,
  input wire logic marker,
  input wire logic [4:0] word_len,
  input wire logic msb_first,
  output var logic [WIDTH-1:0] hold_word
);
  logic [WIDTH-1:0] shreg;
  logic [4:0] count;
  logic [4:0] left_pad;

  // unused high bits are pushed out so the word sits left aligned
  assign left_pad = 5'(WIDTH) - word_len;

  // shifting stops once the programmed length is in
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shreg <= '0;
      count <= '0;
    end else if (marker) begin
      shreg <= '0;
      count <= '0;
    end else if (count < word_len) begin
      count <= count + 5'h01;
      if (msb_first) begin
        shreg <= {shreg[WIDTH-2:0], bit_in};
      end else begin
        shreg <= {bit_in, shreg[WIDTH-1:1]};
      end
    end
  end

  // marker moves the held word, low bits zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_word <= '0;
    end else if (marker) begin
      hold_word <= msb_first ? (shreg << left_pad) : shreg;
    end
  end
endmodule
`default_nettype wire

// ==== sim/fife_front_end_asserts.sv ====
// assertion checker for the filter input front end ports
`timescale 1ns/1ps
`default_nettype none
module fife_front_end_asserts (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] config_byte_bus_out,
  input wire logic config_byte_bus_oe_n,
  input wire logic [fife_pkg::WORD_W-1:0] product_word,
  input wire logic [fife_pkg::WORD_W-1:0] sample_word,
  input wire logic product_valid,
  input wire logic [fife_pkg::WPTR_W-1:0] coef_write_ptr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [3:0] quiet;
  // cycles since a host strobe was last seen low, saturating
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      quiet <= 4'hF;
    end else if (!write_strobe_n || !read_strobe_n) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  property p_ptr_max;
    coef_write_ptr <= 8'h80;
  endproperty
  a_ptr_max: assert property (p_ptr_max) else $error("pointer past end");
  property p_ptr_step;
    $changed(coef_write_ptr) |->
      coef_write_ptr == $past(coef_write_ptr) + 8'h01 || coef_write_ptr == 8'h00;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer jump");
  property p_ptr_cause;
    $changed(coef_write_ptr) |-> quiet < 4'h8;
  endproperty
  a_ptr_cause: assert property (p_ptr_cause) else $error("pointer moved idle");
  property p_oe_cause;
    $fell(config_byte_bus_oe_n) |-> !$past(read_strobe_n, 2) && write_strobe_n;
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive without read");
  property p_oe_release;
    $rose(read_strobe_n) |-> ##[1:6] config_byte_bus_oe_n;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("bus not released");
  property p_oe_idle;
    read_strobe_n [*8] |-> config_byte_bus_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("bus driven idle");
  property p_bus_hold;
    !config_byte_bus_oe_n && !$past(config_byte_bus_oe_n) |->
      $stable(config_byte_bus_out);
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("read byte moved");
  property p_valid_gap;
    product_valid |=> !product_valid [*8];
  endproperty
  a_valid_gap: assert property (p_valid_gap) else $error("valid too close");
  property p_word_update;
    $changed(product_word) || $changed(sample_word) |-> product_valid;
  endproperty
  a_word_update: assert property (p_word_update) else $error("word torn");
  c_product: cover property (product_valid);
  c_read: cover property ($fell(config_byte_bus_oe_n));
  c_full: cover property (coef_write_ptr == 8'h80);
endmodule
bind fife_front_end fife_front_end_asserts u_fife_front_end_asserts (
  .ref_clk(ref_clk), .rstn(rstn), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n), .config_byte_bus_out(config_byte_bus_out),
  .config_byte_bus_oe_n(config_byte_bus_oe_n), .product_word(product_word),
  .sample_word(sample_word), .product_valid(product_valid),
  .coef_write_ptr(coef_write_ptr)
);
`default_nettype wire

// ==== sim/fife_serial_src.sv ====
// serial sender model: sample and mix streams framed by markers
`timescale 1ns/1ps
`default_nettype none
module fife_serial_src (
  input wire logic serial_clk,
  output var logic sample_serial_in,
  output var logic sample_word_marker,
  output var logic mix_serial_in,
  output var logic mix_word_marker
);
  initial begin
    sample_serial_in = 1'b0;
    sample_word_marker = 1'b0;
    mix_serial_in = 1'b0;
    mix_word_marker = 1'b0;
  end
  // one frame of 28 clocks: marker, word bits, then a toggling filler
  task automatic send(input logic [23:0] s, input int len, input logic msb,
      input logic [23:0] m, input logic ser, input logic [1:0] sel);
    int k;
    for (k = 0; k < 28; k++) begin
      @(negedge serial_clk);
      sample_word_marker <= (k == 0);
      sample_serial_in <= (k >= 1 && k <= len) ?
          s[msb ? len - k : k - 1] : k[0];
      if (ser) begin
        mix_word_marker <= (k == 0);
        mix_serial_in <= (k >= 1 && k <= 24) ? m[24 - k] : k[0];
      end else begin
        mix_word_marker <= (k == 0) ? sel[1] : k[0];
        mix_serial_in <= (k == 0) ? sel[0] : ~k[0];
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the filter input front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic serial_clk = 1'b0;
  logic sclk_on = 1'b1;
  logic rstn = 1'b0;
  logic [2:0] register_select_lines = 3'h0;
  logic write_strobe_n = 1'b1;
  logic read_strobe_n = 1'b1;
  logic [7:0] config_byte_bus_in = 8'h00;
  logic [7:0] config_byte_bus_out, coef_write_ptr;
  logic config_byte_bus_oe_n, product_valid;
  logic sample_serial_in, sample_word_marker, mix_serial_in, mix_word_marker;
  logic [23:0] product_word, sample_word;
  logic oe_q = 1'b1;
  logic [48:0] pe;
  logic [7:0] rq[$];
  logic [48:0] pq[$];
  logic [7:0] b[12];
  int err_total = 0;
  int checks = 0;
  int seed = 4010;
  int i;
  // serial clock runs only during reset and serial traffic
  always #12.5 ref_clk = ~ref_clk;
  always #80 if (sclk_on) serial_clk = ~serial_clk;
  fife_front_end u_fife_front_end (
    .ref_clk(ref_clk), .rstn(rstn), .serial_clk(serial_clk),
    .register_select_lines(register_select_lines),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .config_byte_bus_in(config_byte_bus_in),
    .config_byte_bus_out(config_byte_bus_out),
    .config_byte_bus_oe_n(config_byte_bus_oe_n),
    .sample_serial_in(sample_serial_in),
    .sample_word_marker(sample_word_marker),
    .mix_serial_in(mix_serial_in), .mix_word_marker(mix_word_marker),
    .product_word(product_word), .sample_word(sample_word),
    .product_valid(product_valid), .coef_write_ptr(coef_write_ptr)
  );
  fife_serial_src u_fife_serial_src (
    .serial_clk(serial_clk), .sample_serial_in(sample_serial_in),
    .sample_word_marker(sample_word_marker),
    .mix_serial_in(mix_serial_in), .mix_word_marker(mix_word_marker)
  );
  task automatic cmp_byte(input string n, input logic [7:0] e,
      input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp_word(input string n, input logic [23:0] e,
      input logic [23:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // host write: strobe low 5 cycles, address and data held 5 after
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    register_select_lines = a;
    config_byte_bus_in = d;
    write_strobe_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    write_strobe_n = 1'b1;
    repeat (5) @(negedge ref_clk);
  endtask
  // host read: the expected byte is noted first
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(negedge ref_clk);
    register_select_lines = a;
    read_strobe_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    read_strobe_n = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask
  // one serial session; each marker yields the previous word's product
  task automatic session(input logic [7:0] fin, fmix,
      input logic [1:0] sel, input int n);
    logic [23:0] s, m, se;
    logic [24:0] mx;
    logic signed [48:0] pr;
    logic c;
    int j;
    wr(3'h3, fin);
    wr(3'h7, fmix);
    repeat (4) @(negedge serial_clk);
    c = 1'b0;
    for (j = 0; j <= n; j++) begin
      pq.push_back({c, se, pr[46:23]});
      s = 24'($random(seed));
      m = 24'($random(seed));
      se = (s << (24 - fin[4:0])) ^ {fin[5], 23'h0};
      if (fmix[6]) mx = {m[23], m};
      else mx = (sel == 2'h3) ? fife_pkg::MIX_PLUS_ONE :
          (sel == 2'h1) ? fife_pkg::MIX_MINUS_ONE : fife_pkg::MIX_ZERO;
      pr = $signed(se) * $signed(mx);
      c = (j >= 1);
      u_fife_serial_src.send(s, int'(fin[4:0]), fin[6], m, fmix[6], sel);
    end
  endtask
  // monitors take the oldest note whenever a result appears
  always @(negedge ref_clk) begin
    oe_q <= config_byte_bus_oe_n;
    if (config_byte_bus_oe_n === 1'b0 && oe_q === 1'b1) begin
      cmp_byte("read_byte", rq.size() ? rq.pop_front() : 8'hXX,
          config_byte_bus_out);
    end
    if (product_valid === 1'b1) begin
      pe = pq.size() ? pq.pop_front() : {1'b1, 48'hX};
      if (pe[48]) begin
        cmp_word("sample_word", pe[47:24], sample_word);
        cmp_word("product_word", pe[23:0], product_word);
      end
    end
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    sclk_on = 1'b0;
    cmp_byte("write_ptr", 8'h00, coef_write_ptr);
    rd(3'h1, fife_pkg::CFG_RESET);
    wr(3'h0, 8'h00);
    for (i = 0; i < 12; i++) b[i] = 8'($random(seed));
    for (i = 0; i < 8; i++) wr(3'h2, b[i]);
    cmp_byte("write_ptr", 8'h02, coef_write_ptr);
    wr(3'h5, 8'hA5);
    cmp_byte("write_ptr", 8'h00, coef_write_ptr);
    for (i = 8; i < 12; i++) wr(3'h2, b[i]);
    rd(3'h2, 8'h00);
    cmp_byte("write_ptr", 8'h01, coef_write_ptr);
    wr(3'h0, 8'h10);
    for (i = 0; i < 4; i++) wr(3'h2, 8'h5A);
    cmp_byte("write_ptr", 8'h00, coef_write_ptr);
    for (i = 0; i < 8; i++) rd(3'h2, (i < 4) ? b[i + 8] : b[i]);
    wr(3'h0, 8'h00);
    for (i = 0; i < 520; i++) wr(3'h2, 8'($random(seed)));
    cmp_byte("write_ptr", 8'h80, coef_write_ptr);
    rd(3'h5, 8'hA5);
    cmp_byte("write_ptr", 8'h00, coef_write_ptr);
    sclk_on = 1'b1;
    for (i = 0; i < 4; i++) session(8'h58, 8'h00, 2'(i), 4);
    session(8'h2C, 8'h00, 2'h3, 4);
    session(8'h68, 8'h00, 2'h1, 3);
    session(8'h58, 8'h78, 2'h0, 4);
    for (i = 0; i < 400 && pq.size() > 0; i++) @(negedge ref_clk);
    if (pq.size() > 0) begin
      err_total++;
      $display("[ERR] pending_products exp 0 got %0d", pq.size());
    end
    sclk_on = 1'b0;
    stop_test();
  end
endmodule
`default_nettype wire
